// ### include/spd_pkg.sv
// ============================================================================
// speed reference selector constants
// Overview of operation
// (R1) in master/auxiliary switching the first analog input is the reference while step bit one is off, the second while it is on.
// (R2) with the second analog function at 0 (default) the second analog input is added to the first to form the reference.
// (R3) with the analog swap set to 1 the second analog input is master and the first is auxiliary.
// (R4) with the reference source at 4 the reference comes from the frequency of the pulse train terminal.
// (R5) with the pulse input function at 0 the pulse frequency is scaled so the scaling value in hertz is 100 percent.
// (R6) up to 17 speeds exist: 16 stored frequency references plus one jog frequency; here three step bits reach only presets 1 to 8 plus jog.
// (R7) an input with function code 3, 4 or 5 acts as step bit one, two or three, and code 6 makes it jog select.
// (R8) with jog off preset N is chosen, N being one plus bit one plus twice bit two plus four times bit three.
// (R9) while jog select is on the jog frequency is chosen whatever the step bits are.
// (R10) speed 1 comes from the first analog input when the source is 1 and from preset one when the source is 0.
// (R11) speed 2 comes from the second analog input when its function is 2 and from preset two when it is 1F.
// (R12) with the second analog input set as auxiliary, step bit one also does master/auxiliary switching.
// (R13) the reference source encodes 0 panel, 1 analog, 2 serial, 3 option card, 4 pulse train.
// (R14) the pulse input function encodes 0 frequency reference, 1 PID feedback, 2 PID target.
// (R15) contact inputs are synchronised and the selected reference is registered, changing only on a clock edge.
package spd_pkg;
  // ==========================================================================
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int GATE_MS = 100;
  localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_MS;
  localparam logic [16:0] HZ_PER_EDGE = 17'(1000 / GATE_MS);
  localparam logic [16:0] HZ_MAX = 17'h1FFFF;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  // ==========================================================================
  // reference scale: REF_FULL is 100.00 percent
  localparam logic [15:0] REF_FULL = 16'h2710;
  localparam logic [15:0] REF_SAT = 16'hFFFF;
  localparam logic [15:0] SCALE_MIN = 16'h03E8;
  localparam logic [15:0] SCALE_MAX = 16'h7D00;
  // ==========================================================================
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SCALE = 8'h04;
  localparam logic [7:0] OFS_INFN = 8'h08;
  localparam logic [7:0] OFS_INFN3 = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_REFOUT = 8'h14;
  localparam logic [7:0] OFS_PULSEHZ = 8'h18;
  localparam logic [7:0] OFS_PRESET = 8'h40;
  localparam int NUM_PRESET = 17;
  localparam logic [4:0] IDX_JOG = 5'h10;
  localparam logic [5:0] PRESET_COUNT = 6'h11;
  // ==========================================================================
  // field layout and reset values
  localparam logic [31:0] CTRL_MASK = 32'h0003_11F7;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] SCALE_MASK = 32'h0000_FFFF;
  localparam logic [31:0] SCALE_RST = 32'h0000_05A0;
  localparam logic [31:0] INFN_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] INFN_RST = 32'h0605_0403;
  localparam logic [31:0] INFN3_MASK = 32'h0000_00FF;
  localparam logic [31:0] INFN3_RST = 32'h0000_000F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // encodings
  localparam logic [2:0] SRC_PANEL = 3'h0;
  localparam logic [2:0] SRC_ANALOG = 3'h1;
  localparam logic [2:0] SRC_SERIAL = 3'h2;
  localparam logic [2:0] SRC_OPTION = 3'h3;
  localparam logic [2:0] SRC_PULSE = 3'h4;
  localparam logic [1:0] PF_FREQ = 2'h0;
  localparam logic [1:0] PF_PID_FB = 2'h1;
  localparam logic [1:0] PF_PID_TGT = 2'h2;
  localparam logic [4:0] A2_ADD = 5'h00;
  localparam logic [4:0] A2_AUX = 5'h02;
  localparam logic [4:0] A2_UNUSED = 5'h1F;
  localparam logic [7:0] FN_STEP1 = 8'h03;
  localparam logic [7:0] FN_JOG = 8'h06;
  localparam int NUM_CONTACT = 5;
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [13:0] rsvdHi;
    logic [1:0] pulseFunc;
    logic [2:0] rsvdMid;
    logic analogSwap;
    logic [2:0] rsvdLo;
    logic [4:0] secondFunc;
    logic rsvd0;
    logic [2:0] refSource;
  } spd_cfg_t;
  typedef struct packed {
    logic jog;
    logic [2:0] step;
  } spd_sel_t;
  typedef enum logic {DV_IDLE = 1'b0, DV_RUN = 1'b1} spd_dv_t;
endpackage

// ### rtl/spd_preset_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// preset table: one write port, two registered read ports
module spd_preset_mem
  import spd_pkg::*;
#(
  parameter int DEPTH = NUM_PRESET,
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [1:0] wrByteEn,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [4:0] selAddr,
  output logic [WIDTH-1:0] selData,
  input wire logic [4:0] busAddr,
  output logic [WIDTH-1:0] busData
);
  logic [WIDTH-1:0] mem [DEPTH];
  // ==========================================================================
  // storage, byte lanes written separately
  always_ff @(posedge mclk) begin
    if (wrEn && wrByteEn[0]) begin
      mem[wrAddr][7:0] <= wrData[7:0];
    end
    if (wrEn && wrByteEn[1]) begin
      mem[wrAddr][WIDTH-1:8] <= wrData[WIDTH-1:8];
    end
    selData <= mem[selAddr];
    busData <= mem[busAddr];
  end
endmodule
`default_nettype wire

// ### rtl/spd_ref_select.sv
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// speed reference selector with AXI4-Lite register slave
module spd_ref_select
  import spd_pkg::*;
#(
  parameter int GATE_CYCLES_P = GATE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] firstAnalogInput,
  input wire logic [15:0] secondAnalogInput,
  input wire logic [15:0] serialRef,
  input wire logic [15:0] optionRef,
  input wire logic pulseTrainTerminal,
  input wire logic stepSelectContact,
  input wire logic stepBitOneContact,
  input wire logic stepBitTwoContact,
  input wire logic stepBitThreeContact,
  input wire logic jogSelectContact,
  output logic [15:0] freqRef,
  output logic [4:0] speedIndex,
  output logic pulseRefValid
);
  // ==========================================================================
  // register state
  logic [31:0] ctrl_r, ctrl_nxt, scale_r, scale_nxt, infn_r, infn_nxt, infn3_r, infn3_nxt;
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bvalid_r, bvalid_nxt;
  logic [ADDR_W-1:0] awAddr_r, awAddr_nxt, arAddr_r, arAddr_nxt;
  logic [31:0] wData_r, wData_nxt, rdata_r, rdata_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rPend_r, rPend_nxt, rvalid_r, rvalid_nxt;
  logic awTaken, wTaken, doWrite, wInPreset, rInPreset;
  logic [ADDR_W-1:0] wAddr, wOff, rOff, arOff;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [15:0] memSelData, memBusData;
  logic [4:0] memSelAddr;
  spd_cfg_t cfg;
  logic [15:0] scaleEff;

  assign cfg = spd_cfg_t'(ctrl_r);
  assign awTaken = s_axi_awvalid && s_axi_awready;
  assign wTaken = s_axi_wvalid && s_axi_wready;
  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready = !wHeld_r && !bvalid_r;
  assign s_axi_arready = !rPend_r && !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  // write path picks the held or the just-offered beat
  assign wAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
  assign wData = wHeld_r ? wData_r : s_axi_wdata;
  assign wStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
  assign doWrite = (awHeld_r || awTaken) && (wHeld_r || wTaken) && !bvalid_r;
  assign wOff = wAddr - OFS_PRESET;
  assign arOff = s_axi_araddr - OFS_PRESET;
  assign rOff = arAddr_r - OFS_PRESET;
  assign wInPreset = (wAddr >= OFS_PRESET) && ({2'h0, wOff[7:2]} < {2'h0, PRESET_COUNT}) && (wOff[1:0] == 2'h0);
  assign rInPreset = (arAddr_r >= OFS_PRESET) && ({2'h0, rOff[7:2]} < {2'h0, PRESET_COUNT}) && (rOff[1:0] == 2'h0);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // ==========================================================================
  // write channel and configuration registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    scale_nxt = scale_r;
    infn_nxt = infn_r;
    infn3_nxt = infn3_r;
    awHeld_nxt = (awHeld_r || awTaken) && !doWrite;
    wHeld_nxt = (wHeld_r || wTaken) && !doWrite;
    awAddr_nxt = awTaken ? s_axi_awaddr : awAddr_r;
    wData_nxt = wTaken ? s_axi_wdata : wData_r;
    wStrb_nxt = wTaken ? s_axi_wstrb : wStrb_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    if (doWrite) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (wAddr)
        OFS_CTRL: ctrl_nxt = merge(ctrl_r, wData, wStrb, CTRL_MASK);
        OFS_SCALE: scale_nxt = merge(scale_r, wData, wStrb, SCALE_MASK);
        OFS_INFN: infn_nxt = merge(infn_r, wData, wStrb, INFN_MASK);
        OFS_INFN3: infn3_nxt = merge(infn3_r, wData, wStrb, INFN3_MASK);
        OFS_STATUS, OFS_REFOUT, OFS_PULSEHZ: bresp_nxt = RESP_OKAY; // read only, write ignored
        default: bresp_nxt = wInPreset ? RESP_OKAY : RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      scale_r <= SCALE_RST;
      infn_r <= INFN_RST;
      infn3_r <= INFN3_RST;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      ctrl_r <= ctrl_nxt;
      scale_r <= scale_nxt;
      infn_r <= infn_nxt;
      infn3_r <= infn3_nxt;
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // ==========================================================================
  // preset and jog table, 16 stored references plus jog
  spd_preset_mem #(.DEPTH(NUM_PRESET), .WIDTH(16)) presetMem ( // see (R6)
    .mclk(mclk),
    .wrEn(doWrite && wInPreset),
    .wrAddr(wOff[6:2]),
    .wrByteEn(wStrb[1:0]),
    .wrData(wData[15:0]),
    .selAddr(memSelAddr),
    .selData(memSelData),
    .busAddr(arOff[6:2]),
    .busData(memBusData)
  );

  // ==========================================================================
  // contact synchronisers and role decode
  logic [NUM_CONTACT-1:0] contactRaw, syncA_r, syncB_r;
  logic [NUM_CONTACT-1:0] hitStep1, hitStep2, hitStep3, hitJog;
  logic [7:0] fnCode [NUM_CONTACT];
  spd_sel_t sel;

  assign contactRaw = {jogSelectContact, stepBitThreeContact, stepBitTwoContact, stepBitOneContact, stepSelectContact};
  assign fnCode[0] = infn3_r[7:0];

  genvar gk;
  generate
    for (gk = 0; gk < NUM_CONTACT; gk++) begin : gRole
      if (gk > 0) begin : gFn
        assign fnCode[gk] = infn_r[(gk-1)*8 +: 8];
      end
      assign hitStep1[gk] = syncB_r[gk] && (fnCode[gk] == FN_STEP1); // see (R7)
      assign hitStep2[gk] = syncB_r[gk] && (fnCode[gk] == FN_STEP1 + 8'h01); // see (R7)
      assign hitStep3[gk] = syncB_r[gk] && (fnCode[gk] == FN_STEP1 + 8'h02); // see (R7)
      assign hitJog[gk] = syncB_r[gk] && (fnCode[gk] == FN_JOG); // see (R7)
    end
  endgenerate

  assign sel.step = {|hitStep3, |hitStep2, |hitStep1};
  assign sel.jog = |hitJog;
  // jog wins over the step bits; otherwise preset index is the binary step code
  assign memSelAddr = sel.jog ? IDX_JOG : {2'h0, sel.step}; // see (R8) see (R9)

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= contactRaw; // see (R15)
      syncB_r <= syncA_r;
    end
  end

  // ==========================================================================
  // pulse train frequency measurement and scaling
  logic pulseA_r, pulseB_r, pulseC_r;
  logic [31:0] gateCnt_r, gateCnt_nxt;
  logic [16:0] edgeHz_r, edgeHz_nxt, pulseHz_r, pulseHz_nxt;
  logic gateTick;
  spd_dv_t dvState_r, dvState_nxt;
  logic [31:0] quo_r, quo_nxt;
  logic [16:0] rem_r, rem_nxt, remSh;
  logic [5:0] dvCnt_r, dvCnt_nxt;
  logic [15:0] pulseRef_r, pulseRef_nxt;
  logic pulseValid_r, pulseValid_nxt;

  assign gateTick = (gateCnt_r == 32'(GATE_CYCLES_P - 1));
  // scaling kept inside its documented range so the divisor is never zero
  assign scaleEff = (scale_r[15:0] < SCALE_MIN) ? SCALE_MIN : (scale_r[15:0] > SCALE_MAX) ? SCALE_MAX : scale_r[15:0];
  assign remSh = {rem_r[15:0], quo_r[31]};

  always_comb begin
    gateCnt_nxt = gateTick ? '0 : gateCnt_r + 32'h1;
    edgeHz_nxt = edgeHz_r;
    if (pulseB_r && !pulseC_r) begin
      edgeHz_nxt = (edgeHz_r > HZ_MAX - HZ_PER_EDGE) ? HZ_MAX : edgeHz_r + HZ_PER_EDGE;
    end
    pulseHz_nxt = pulseHz_r;
    dvState_nxt = dvState_r;
    quo_nxt = quo_r;
    rem_nxt = rem_r;
    dvCnt_nxt = dvCnt_r;
    pulseRef_nxt = pulseRef_r;
    pulseValid_nxt = pulseValid_r;
    if (gateTick) begin
      edgeHz_nxt = '0;
      pulseHz_nxt = edgeHz_r;
    end
    unique case (dvState_r)
      DV_IDLE: begin
        if (gateTick) begin
          dvState_nxt = DV_RUN;
          quo_nxt = 32'(edgeHz_r) * 32'(REF_FULL); // see (R5)
          rem_nxt = '0;
          dvCnt_nxt = '0;
        end
      end
      DV_RUN: begin
        rem_nxt = (remSh >= {1'b0, scaleEff}) ? remSh - {1'b0, scaleEff} : remSh;
        quo_nxt = {quo_r[30:0], remSh >= {1'b0, scaleEff}};
        dvCnt_nxt = dvCnt_r + 6'h01;
        if (dvCnt_r == DIV_STEPS - 6'h01) begin
          dvState_nxt = DV_IDLE;
          pulseRef_nxt = (quo_nxt[31:16] != 16'h0) ? REF_SAT : quo_nxt[15:0];
          pulseValid_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pulseA_r <= 1'b0;
      pulseB_r <= 1'b0;
      pulseC_r <= 1'b0;
      gateCnt_r <= '0;
      edgeHz_r <= '0;
      pulseHz_r <= '0;
      dvState_r <= DV_IDLE;
      quo_r <= '0;
      rem_r <= '0;
      dvCnt_r <= '0;
      pulseRef_r <= '0;
      pulseValid_r <= 1'b0;
    end else begin
      pulseA_r <= pulseTrainTerminal;
      pulseB_r <= pulseA_r;
      pulseC_r <= pulseB_r;
      gateCnt_r <= gateCnt_nxt;
      edgeHz_r <= edgeHz_nxt;
      pulseHz_r <= pulseHz_nxt;
      dvState_r <= dvState_nxt;
      quo_r <= quo_nxt;
      rem_r <= rem_nxt;
      dvCnt_r <= dvCnt_nxt;
      pulseRef_r <= pulseRef_nxt;
      pulseValid_r <= pulseValid_nxt;
    end
  end

  // ==========================================================================
  // reference selection, registered output
  logic [4:0] selIdx_r, idxOut_r;
  logic [15:0] ref_r, ref_nxt, masterRef, auxRef;
  logic [16:0] analogSum;

  assign analogSum = {1'b0, firstAnalogInput} + {1'b0, secondAnalogInput};
  always_comb begin
    masterRef = cfg.analogSwap ? secondAnalogInput : firstAnalogInput; // see (R3)
    auxRef = cfg.analogSwap ? firstAnalogInput : secondAnalogInput; // see (R3)
    if (cfg.secondFunc == A2_ADD) begin
      masterRef = analogSum[16] ? REF_SAT : analogSum[15:0]; // see (R2)
    end
    ref_nxt = memSelData;
    if (selIdx_r == 5'h00) begin
      unique case (cfg.refSource) // see (R13)
        SRC_ANALOG: ref_nxt = masterRef; // see (R1) see (R10)
        SRC_SERIAL: ref_nxt = serialRef;
        SRC_OPTION: ref_nxt = optionRef;
        SRC_PULSE: ref_nxt = (cfg.pulseFunc == PF_FREQ) ? pulseRef_r : memSelData; // see (R4) see (R14)
        default: ref_nxt = memSelData; // see (R10)
      endcase
    end else if (selIdx_r == 5'h01 && cfg.secondFunc == A2_AUX) begin
      ref_nxt = auxRef; // see (R1) see (R11) see (R12)
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      selIdx_r <= '0;
      idxOut_r <= 5'h01;
      ref_r <= '0;
    end else begin
      selIdx_r <= memSelAddr;
      idxOut_r <= selIdx_r + 5'h01;
      ref_r <= ref_nxt; // see (R15)
    end
  end

  assign freqRef = ref_r;
  assign speedIndex = idxOut_r;
  assign pulseRefValid = pulseValid_r;

  // ==========================================================================
  // read channel
  always_comb begin
    rPend_nxt = 1'b0;
    arAddr_nxt = arAddr_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rPend_nxt = 1'b1;
      arAddr_nxt = s_axi_araddr;
    end
    if (rPend_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (arAddr_r)
        OFS_CTRL: rdata_nxt = ctrl_r;
        OFS_SCALE: rdata_nxt = scale_r;
        OFS_INFN: rdata_nxt = infn_r;
        OFS_INFN3: rdata_nxt = infn3_r;
        OFS_STATUS: rdata_nxt = {11'h0, syncB_r, 7'h0, pulseValid_r, 3'h0, idxOut_r};
        OFS_REFOUT: rdata_nxt = {16'h0, ref_r};
        OFS_PULSEHZ: rdata_nxt = {15'h0, pulseHz_r};
        default: begin
          rdata_nxt = rInPreset ? {16'h0, memBusData} : 32'h0;
          rresp_nxt = rInPreset ? RESP_OKAY : RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rPend_r <= 1'b0;
      arAddr_r <= '0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      rPend_r <= rPend_nxt;
      arAddr_r <= arAddr_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
endmodule
`default_nettype wire

// ### tb/spd_ref_select_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// handshake and selection checks
module spd_ref_select_properties
  import spd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic stepSelectContact,
  input wire logic stepBitOneContact,
  input wire logic stepBitTwoContact,
  input wire logic stepBitThreeContact,
  input wire logic jogSelectContact,
  input wire logic [15:0] freqRef,
  input wire logic [4:0] speedIndex,
  input wire logic pulseRefValid
);
  logic [4:0] contNow;
  logic [4:0] contPrev_r;
  logic [3:0] quiet_r, quiet_nxt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign contNow = {jogSelectContact, stepBitThreeContact, stepBitTwoContact, stepBitOneContact, stepSelectContact};
  // cycles since the last contact change or register write
  always_comb begin
    quiet_nxt = (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
    if (contNow != contPrev_r || s_axi_bvalid) quiet_nxt = 4'h0;
  end
  always_ff @(posedge mclk) begin
    contPrev_r <= contNow;
    quiet_r <= rst_n ? quiet_nxt : 4'h0;
  end
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read data timing wrong");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
    |=> ##1 s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_index_legal: assert property (speedIndex inside {[5'h01:5'h08], 5'h11})
    else $error("speed index out of range");
  a_reset_values: assert property ($rose(rst_n) |-> speedIndex == 5'h01 && freqRef == 16'h0 && !pulseRefValid)
    else $error("output not cleared by reset");
  a_index_cause: assert property ($changed(speedIndex) |-> quiet_r < 4'h8)
    else $error("speed index moved without a cause");
  c_jog: cover property (speedIndex == 5'h11);
  c_pulse: cover property ($rose(pulseRefValid));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
`default_nettype wire

// ### tb/spd_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// contact bank and pulse source
module spd_far_side (
  input wire logic mclk,
  input wire logic [4:0] cmd,
  input wire logic [3:0] halfP,
  output logic [4:0] contacts,
  output logic pulseTrainTerminal
);
  logic [3:0] cnt;
  initial begin
    contacts = 5'h00;
    pulseTrainTerminal = 1'b0;
    cnt = 4'h0;
  end
  // contacts follow the command a cycle late; pulse period is 2*halfP, idle low
  always @(posedge mclk) begin
    contacts <= cmd;
    if (halfP == 4'h0) begin
      cnt <= 4'h0;
      pulseTrainTerminal <= 1'b0;
    end else if (cnt == halfP - 4'h1) begin
      cnt <= 4'h0;
      pulseTrainTerminal <= ~pulseTrainTerminal;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb/spd_ref_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// bench top
module spd_ref_select_tb
  import spd_pkg::*;
;
  logic mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pulseTrainTerminal, pulseRefValid;
  logic stepSelectContact, stepBitOneContact, stepBitTwoContact, stepBitThreeContact, jogSelectContact;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, halfP;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] firstAnalogInput, secondAnalogInput, serialRef, optionRef, freqRef;
  logic [4:0] speedIndex, cmd, ct;
  int fail_count, cmp_count, cyc, i;
  logic [15:0] tc [9] = '{16'h01F0, 16'h0001, 16'h0021, 16'h0021, 16'h1021, 16'h1021, 16'h01F2, 16'h01F3, 16'h01F1};
  logic [4:0] tm [9] = '{5'h00, 5'h00, 5'h00, 5'h02, 5'h00, 5'h02, 5'h00, 5'h00, 5'h02};
  logic [15:0] te [9] = '{16'h1100, 16'h1234, 16'h1000, 16'h0234, 16'h0234, 16'h1000, 16'h2222, 16'h3333, 16'h1101};
  spd_ref_select #(.GATE_CYCLES_P(200)) u_dut (.*);
  spd_far_side u_far (.mclk(mclk), .cmd(cmd), .halfP(halfP), .contacts(ct), .pulseTrainTerminal(pulseTrainTerminal));
  assign {jogSelectContact, stepBitThreeContact, stepBitTwoContact, stepBitOneContact, stepSelectContact} = ct;
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // waits for the answer however long; only the hang guard ends a stuck wait
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task cont(input logic [4:0] v);
    @(posedge mclk);
    cmd <= v;
    repeat (8) @(posedge mclk);
  endtask
  // main sequence
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd, halfP, fail_count, cmp_count, cyc} = '0;
    s_axi_wstrb = 4'hF;
    firstAnalogInput = 16'h1000;
    secondAnalogInput = 16'h0234;
    serialRef = 16'h2222;
    optionRef = 16'h3333;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    axr(OFS_CTRL);
    chk(rd, CTRL_RST);
    axr(OFS_SCALE);
    chk(rd, SCALE_RST);
    axr(OFS_INFN);
    chk(rd, INFN_RST);
    for (i = 0; i < 16; i++) axw(OFS_PRESET + 8'(4 * i), 32'h1100 + i);
    axw(8'h80, 32'h0ABC);
    axw(OFS_CTRL, 32'h01F0);
    for (i = 0; i < 16; i++) begin
      cont({i[3], i[2:0], 1'b0});
      chk(speedIndex, i < 8 ? 32'(i + 1) : 32'h11);
      chk(freqRef, i < 8 ? 32'h1100 + i : 32'h0ABC);
    end
    cont(5'h00);
    cmd <= 5'h04;
    repeat (2) @(posedge mclk);
    chk(speedIndex, 32'h1);
    repeat (6) @(posedge mclk);
    chk(speedIndex, 32'h3);
    axw(OFS_INFN, 32'h0305_0406);
    cont(5'h02);
    chk(speedIndex, 32'h11);
    axw(OFS_INFN, INFN_RST);
    axw(OFS_INFN3, 32'h04);
    cont(5'h01);
    chk(speedIndex, 32'h3);
    axw(OFS_INFN3, 32'h0F);
    for (i = 0; i < 9; i++) begin
      axw(OFS_CTRL, 32'(tc[i]));
      cont(tm[i]);
      chk(freqRef, 32'(te[i]));
    end
    axr(8'h20);
    chk(rd, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    axw(8'h20, 32'h5);
    chk(rsp, RESP_SLVERR);
    // 200-cycle gate, period 10: 20 edges, 200 Hz, 200*10000/1000
    axw(OFS_SCALE, 32'h03E8);
    axw(OFS_CTRL, 32'h0004);
    cont(5'h00);
    halfP <= 4'h5;
    for (i = 0; i < 2000 && pulseRefValid !== 1'b1; i++) @(posedge mclk);
    repeat (500) @(posedge mclk);
    chk(32'(pulseRefValid), 32'h1);
    chk(freqRef, 32'h07D0);
    axr(OFS_REFOUT);
    chk(rd, 32'h07D0);
    axr(OFS_PULSEHZ);
    chk(rd, 32'hC8);
    axw(OFS_CTRL, 32'h0001_0004);
    repeat (4) @(posedge mclk);
    chk(freqRef, 32'h1100);
    end_of_test();
  end
endmodule
bind spd_ref_select spd_ref_select_properties u_chk (.*);
`default_nettype wire
